//--- include/ksi_defines.svh
`ifndef KSI_DEFINES_SVH
`define KSI_DEFINES_SVH

// Clock and timing
`define KSI_CLK_MHZ        200
`define KSI_PULSE_NS       2000
`define KSI_PULSE_CYC      ((`KSI_PULSE_NS * `KSI_CLK_MHZ + 999) / 1000)
`define KSI_UNIT_US        9090
`define KSI_UNIT_CYC       (`KSI_UNIT_US * `KSI_CLK_MHZ)

// Function word layout
`define KSI_FWORD_W        6
`define KSI_FW_INPUT_BIT   3
`define KSI_FW_KBD_BIT     4
`define KSI_FW_KBD         6'h18
`define KSI_FW_KBD_CLR     6'h19

// Character frame layout, in units from initiation
`define KSI_DATA_W         7
`define KSI_FRAME_FIRST    4'h1
`define KSI_FRAME_LAST     4'h7
`define KSI_FRAME_STOP     4'h9
`define KSI_FRAME_END      4'hA
`define KSI_FIFO_DEPTH     4

`endif

//--- include/ksi_pkg.sv
`default_nettype none

package ksi_pkg;

    typedef enum logic [1:0] {
        DS_IDLE  = 2'b00,
        DS_START = 2'b01,
        DS_FRAME = 2'b10
    } deser_state_t;

    // Pin inputs, all asynchronous to i_clock
    typedef struct packed {
        logic       function_word_ack;
        logic [5:0] function_word;
        logic       key_line;
        logic       tape_feed_busy;
        logic       punch_busy;
        logic       punch_ready;
        logic       online;
        logic       printer_ready;
        logic       reader_mode;
        logic       key_request_latch;
    } pins_t;

    typedef struct packed {
        logic [6:0] code;
    } key_char_t;

endpackage

`default_nettype wire

//--- src/keyboard_serial_input_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "ksi_defines.svh"

module ksi_fifo #(
    parameter int WIDTH = 7,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clock,      // System clock
    input  wire logic             i_rst_n,      // Sync reset, active low
    input  wire logic             i_in_valid,   // Write request
    output logic                  o_in_ready,   // Space available
    input  wire logic [WIDTH-1:0] i_in_data,    // Write data
    output logic                  o_out_valid,  // Data available
    input  wire logic             i_out_ready,  // Reader takes a word
    output logic      [WIDTH-1:0] o_out_data    // Head word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign o_in_ready  = count != (AW+1)'(DEPTH);
    assign o_out_valid = count != '0;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem[rd_ptr];

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module keyboard_serial_input_control
    import ksi_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = `KSI_UNIT_CYC
) (
    input  wire logic       i_clock,               // 200 MHz system clock
    input  wire logic       i_rst_n,               // Sync reset, active low
    input  wire pins_t      i_pins,                // Asynchronous pin inputs
    input  wire logic       i_char_ready,          // Host side takes a character
    output logic            o_char_valid,          // Character waiting
    output key_char_t       o_char,                // Oldest received character
    output logic            o_keyboard_mode,       // Keyboard mode latched
    output logic            o_keyboard_lamp,       // Keyboard indicator
    output logic            o_reader_block,        // Tape reader path blocked
    output logic            o_printer_motor_on,    // Printer motor drive
    output logic            o_output_reg_clear,    // Clear output register
    output logic            o_output_func_clear,   // Clear output functions (word 031)
    output logic            o_output_request_en,   // Output data request enable
    output logic            o_function_request_block, // Block function-word requests
    output logic            o_deserializer_idle_line, // Deserializer idle
    output logic            o_key_strobe,          // Deserializer busy strobe
    output logic            o_key_input_armed,     // Key input armed
    output logic            o_sampling_gate,       // Data sampling gate
    output logic            o_input_reg_clear,     // Input register held clear
    output logic [6:0]      o_input_data           // Input register
);
    localparam int          QUAL_CYC   = `KSI_PULSE_CYC;
    localparam logic [20:0] UNIT_LAST  = 21'(UNIT_CYCLES - 1);
    localparam logic [20:0] UNIT_HALF  = 21'(UNIT_CYCLES / 2);

    pins_t        pin_meta;
    pins_t        pin;
    logic         ack_prev;
    logic [8:0]   qual_cnt;
    logic         qual;
    logic         input_device_n;
    logic         keyboard_enable_bit_n;
    logic         kbd_mode;
    logic         line_level;
    logic         idle;
    deser_state_t state;
    logic [8:0]   start_cnt;
    logic [20:0]  unit_cnt;
    logic [3:0]   frame;
    logic         armed;
    logic [6:0]   shift;
    logic         push;
    logic         fifo_in_ready;
    logic         unit_end;
    logic         sample_pt;

    // Pins pass two flops before use
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pin_meta <= '0;
            pin      <= '0;
        end else begin
            pin_meta <= i_pins;
            pin      <= pin_meta;
        end
    end

    // Qualifying pulse on acknowledge edge
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ack_prev <= 1'b0;
            qual_cnt <= '0;
            qual     <= 1'b0;
        end else begin
            ack_prev <= pin.function_word_ack;
            if (pin.function_word_ack && !ack_prev) begin
                qual     <= 1'b1;
                qual_cnt <= '0;
            end else if (qual) begin
                qual_cnt <= qual_cnt + 1'b1;
                if (qual_cnt == 9'(QUAL_CYC - 1)) begin
                    qual <= 1'b0;
                end
            end
        end
    end

    assign input_device_n        = !pin.function_word[`KSI_FW_INPUT_BIT];
    assign keyboard_enable_bit_n = !pin.function_word[`KSI_FW_KBD_BIT];
    // Mode latch; a qualified word lacking bit 3 or bit 4 drops keyboard mode
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            kbd_mode            <= 1'b0;
            o_output_func_clear <= 1'b0;
        end else begin
            o_output_func_clear <= qual && pin.function_word == `KSI_FW_KBD_CLR;
            if (qual && (pin.function_word == `KSI_FW_KBD || pin.function_word == `KSI_FW_KBD_CLR)
                && !input_device_n && !keyboard_enable_bit_n && !pin.reader_mode) begin
                kbd_mode <= 1'b1;
            end else if (qual && (input_device_n || keyboard_enable_bit_n)) begin
                kbd_mode <= 1'b0;
            end
        end
    end

    // Registered control outputs
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_printer_motor_on  <= 1'b0;
            o_output_reg_clear  <= 1'b0;
            o_output_request_en <= 1'b0;
        end else begin
            o_printer_motor_on  <= kbd_mode;
            o_output_reg_clear  <= kbd_mode && !pin.tape_feed_busy && !pin.punch_busy;
            o_output_request_en <= (pin.punch_ready && pin.online) || pin.printer_ready;
        end
    end

    assign o_keyboard_mode = kbd_mode;
    assign o_keyboard_lamp = kbd_mode;
    assign o_reader_block  = kbd_mode;

    // Line level follows the line only in keyboard mode
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            line_level <= 1'b1;
        end else if (kbd_mode) begin
            line_level <= pin.key_line;
        end else begin
            line_level <= 1'b1;
        end
    end

    assign unit_end  = unit_cnt == UNIT_LAST;
    assign sample_pt = unit_cnt == UNIT_HALF;
    // Deserializer timebase
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state     <= DS_IDLE;
            idle      <= 1'b1;
            start_cnt <= '0;
            unit_cnt  <= '0;
            frame     <= '0;
        end else if (idle && !line_level && state != DS_START) begin
            state     <= DS_START;
            start_cnt <= '0;
            unit_cnt  <= '0;
            frame     <= '0;
        end else begin
            unique case (state)
                DS_IDLE: begin
                    unit_cnt <= '0;
                end
                DS_START: begin
                    start_cnt <= start_cnt + 1'b1;
                    unit_cnt  <= unit_cnt + 1'b1;
                    if (start_cnt == 9'(QUAL_CYC - 1)) begin
                        idle  <= 1'b0;
                        state <= DS_FRAME;
                    end
                end
                DS_FRAME: begin
                    if (unit_end) begin
                        unit_cnt <= '0;
                        if (frame == `KSI_FRAME_END) begin
                            state <= DS_IDLE;
                        end else begin
                            frame <= frame + 1'b1;
                            if (frame + 1'b1 == `KSI_FRAME_STOP) begin
                                idle <= 1'b1;
                            end
                        end
                    end else begin
                        unit_cnt <= unit_cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    assign o_deserializer_idle_line = idle;
    assign o_key_strobe             = !idle;
    assign o_function_request_block = !idle;

    // Arming; a full FIFO stalls arming, so a key received while full is dropped
    assign push = armed && state == DS_FRAME && unit_end && frame == `KSI_FRAME_STOP - 1'b1;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            armed <= 1'b0;
        end else if (push) begin
            armed <= 1'b0;
        end else if (!idle && kbd_mode && !pin.reader_mode && !pin.key_request_latch
                     && fifo_in_ready && state == DS_FRAME && frame < `KSI_FRAME_FIRST) begin
            armed <= 1'b1;
        end
    end

    assign o_key_input_armed = armed;
    assign o_sampling_gate   = armed;
    assign o_input_reg_clear = !armed;

    // Mid-frame sampling into the input register
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !armed) begin
            shift <= '0;
        end else if (sample_pt && state == DS_FRAME && frame >= `KSI_FRAME_FIRST
                     && frame <= `KSI_FRAME_LAST && pin.key_line) begin
            shift[3'(frame - `KSI_FRAME_FIRST)] <= 1'b1;
        end
    end

    assign o_input_data = shift;
    ksi_fifo #(
        .WIDTH (`KSI_DATA_W),
        .DEPTH (`KSI_FIFO_DEPTH)
    ) i_ksi_fifo (
        .i_clock     (i_clock),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (shift),
        .o_out_valid (o_char_valid),
        .i_out_ready (i_char_ready),
        .o_out_data  (o_char.code)
    );

    AST_QUAL_LEN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $fell(qual) |-> $past(qual_cnt) == 9'(QUAL_CYC - 1))
        else $error("qualifying pulse length wrong");
    AST_KBD_SELECT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        qual && pin.function_word == `KSI_FW_KBD && !pin.reader_mode |=> kbd_mode)
        else $error("keyboard word did not select keyboard");
    AST_KBD_CAUSE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(kbd_mode) |-> $past(qual) && !$past(pin.reader_mode))
        else $error("keyboard mode without qualified word");
    AST_MOTOR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        kbd_mode [*2] |-> o_printer_motor_on)
        else $error("motor off in keyboard mode");
    AST_OUT_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_output_reg_clear |-> $past(kbd_mode) && !$past(pin.punch_busy) && !$past(pin.tape_feed_busy))
        else $error("output clear during punch");
    AST_OUT_REQ: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !(pin.punch_ready && pin.online) && !pin.printer_ready |=> !o_output_request_en)
        else $error("output request not suppressed");
    AST_START_PULSE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $fell(idle) |-> $past(state) == DS_START && $past(start_cnt) == 9'(QUAL_CYC - 1))
        else $error("idle cleared off pulse end");
    AST_ARM: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(armed) |-> !$past(idle) && $past(kbd_mode) && !$past(pin.key_request_latch))
        else $error("armed without conditions");
    AST_REG_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !armed ##1 !armed |-> o_input_data == '0)
        else $error("input register not held clear");
    AST_REARM: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(idle) |-> frame == `KSI_FRAME_STOP && unit_cnt == '0)
        else $error("idle set outside stop window");
    AST_SAMPLE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        armed && sample_pt && state == DS_FRAME && frame == `KSI_FRAME_FIRST && pin.key_line
        |=> o_input_data[0])
        else $error("mark not stored");

    COV_SELECT: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(kbd_mode));
    COV_START:  cover property (@(posedge i_clock) disable iff (!i_rst_n) $fell(idle));
    COV_PUSH:   cover property (@(posedge i_clock) disable iff (!i_rst_n) push);
    COV_FULL:   cover property (@(posedge i_clock) disable iff (!i_rst_n) !fifo_in_ready);
endmodule

`default_nettype wire

//--- tb/kb_sender.sv
`timescale 1ns/1ps
`default_nettype none

module kb_sender #(
    parameter int unsigned UNIT = 40
) (
    input  wire logic       i_clock,  // System clock
    input  wire logic       i_rst_n,  // Sync reset, active low
    input  wire logic       i_send,   // Start one keystroke
    input  wire logic [6:0] i_code,   // Key code, bit 0 sent first
    output logic            o_line,   // Serial line, 1 = mark
    output logic            o_busy    // Keystroke in progress
);
    logic [10:0] frame;
    logic [3:0]  units;
    int unsigned cnt;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            units <= 4'h0;
        end else if (units == 4'h0) begin
            if (i_send) begin
                frame <= {3'b111, i_code, 1'b0};
                units <= 4'hB;
                cnt   <= 0;
            end
        end else if (cnt == UNIT - 1) begin
            frame <= {1'b1, frame[10:1]};
            units <= units - 4'h1;
            cnt   <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end

    // Line rests at mark between keystrokes
    assign o_line = (units == 4'h0) ? 1'b1 : frame[0];
    assign o_busy = (units != 4'h0);
endmodule

`default_nettype wire

//--- tb/keyboard_serial_input_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module keyboard_serial_input_control_tb
    import ksi_pkg::*;
;
    localparam int unsigned U     = 1000;
    localparam int unsigned LIMIT = 85000;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    pins_t       pins_r;
    pins_t       pins;
    logic        ready = 1'b0;
    logic        send = 1'b0;
    logic [6:0]  kb_code = 7'h00;
    logic        kb_line;
    logic        kb_busy;
    logic        o_char_valid, o_keyboard_mode, o_keyboard_lamp, o_reader_block, o_printer_motor_on;
    logic        o_output_reg_clear, o_output_func_clear, o_output_request_en, o_function_request_block;
    logic        o_deserializer_idle_line, o_key_strobe, o_key_input_armed, o_sampling_gate;
    logic        o_input_reg_clear;
    logic [6:0]  o_input_data;
    key_char_t   o_char;
    int unsigned error_cnt = 0;
    int unsigned tests_run = 0;
    int unsigned cycles = 0;
    logic [6:0]  codes [4] = '{7'h00, 7'h7F, 7'h55, 7'h2A};

    always #2.5 clk = ~clk;

    always_comb begin
        pins = pins_r;
        pins.key_line = kb_line;
    end

    keyboard_serial_input_control #(.UNIT_CYCLES(U)) i_keyboard_serial_input_control (
        .i_clock(clk), .i_rst_n(rst_n), .i_pins(pins), .i_char_ready(ready),
        .o_char_valid(o_char_valid), .o_char(o_char), .o_keyboard_mode(o_keyboard_mode),
        .o_keyboard_lamp(o_keyboard_lamp), .o_reader_block(o_reader_block),
        .o_printer_motor_on(o_printer_motor_on), .o_output_reg_clear(o_output_reg_clear),
        .o_output_func_clear(o_output_func_clear), .o_output_request_en(o_output_request_en),
        .o_function_request_block(o_function_request_block),
        .o_deserializer_idle_line(o_deserializer_idle_line), .o_key_strobe(o_key_strobe),
        .o_key_input_armed(o_key_input_armed), .o_sampling_gate(o_sampling_gate),
        .o_input_reg_clear(o_input_reg_clear), .o_input_data(o_input_data));

    kb_sender #(.UNIT(U)) i_kb_sender (
        .i_clock(clk), .i_rst_n(rst_n), .i_send(send), .i_code(kb_code), .o_line(kb_line), .o_busy(kb_busy));

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Word must stay put through the whole qualifying window
    task automatic fword(input logic [5:0] word, input logic [1:0] busy, input logic mode, input logic fclr);
        @(posedge clk);
        pins_r.function_word <= word;
        pins_r.tape_feed_busy <= busy[0];
        pins_r.punch_busy <= busy[1];
        @(posedge clk);
        pins_r.function_word_ack <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check(o_keyboard_mode, mode);
        check(o_keyboard_lamp, mode);
        check(o_reader_block, mode);
        check(o_printer_motor_on, mode);
        check(o_output_reg_clear, mode & (busy == 2'b00));
        check(o_output_func_clear, fclr);
        @(posedge clk);
        pins_r.function_word_ack <= 1'b0;
        repeat (420) @(posedge clk);
    endtask

    task automatic request_table();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            pins_r.punch_ready <= i[0];
            pins_r.online <= i[1];
            pins_r.printer_ready <= i[2];
            repeat (5) @(posedge clk);
            #1;
            check(o_output_request_en, (i[0] & i[1]) | i[2]);
        end
    endtask

    task automatic rx_char(input logic [6:0] code, input logic arm);
        int unsigned n;
        n = 0;
        @(posedge clk);
        send <= 1'b1;
        kb_code <= code;
        @(posedge clk);
        send <= 1'b0;
        repeat (600) if (o_deserializer_idle_line) begin
            @(posedge clk);
            #1;
        end
        check(o_deserializer_idle_line, 1'b0);
        check(o_key_strobe, 1'b1);
        check(o_function_request_block, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        check(o_key_input_armed, arm);
        check(o_sampling_gate, arm);
        check(o_input_reg_clear, !arm);
        while (!o_deserializer_idle_line && n < 10 * U) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n >= 9 * U - 412 && n <= 9 * U - 388, 1'b1);
        check(o_function_request_block, 1'b0);
        check(o_input_data, arm ? code : 7'h00);
        @(posedge clk);
        #1;
        check(o_input_data, 7'h00);
        repeat (3 * U) if (kb_busy) @(posedge clk);
    endtask

    // Four keys fill the buffer; a fifth must not be armed
    task automatic fill_and_drain();
        for (int i = 0; i < 4; i++) begin
            rx_char(codes[i], 1'b1);
        end
        rx_char(7'h33, 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            check(o_char_valid, 1'b1);
            check(o_char.code, codes[i]);
            @(posedge clk);
            ready <= 1'b1;
            @(posedge clk);
            ready <= 1'b0;
        end
        @(posedge clk);
        #1;
        check(o_char_valid, 1'b0);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        pins_r = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(o_deserializer_idle_line, 1'b1);
        check(o_keyboard_mode, 1'b0);
        check(o_input_reg_clear, 1'b1);
        check(o_char_valid, 1'b0);
        repeat (4) @(posedge clk);
        request_table();
        fword(6'h18, 2'b00, 1'b1, 1'b0);
        fword(6'h08, 2'b00, 1'b0, 1'b0);
        fword(6'h18, 2'b01, 1'b1, 1'b0);
        fword(6'h10, 2'b00, 1'b0, 1'b0);
        pins_r.reader_mode <= 1'b1;
        fword(6'h18, 2'b00, 1'b0, 1'b0);
        pins_r.reader_mode <= 1'b0;
        fword(6'h18, 2'b10, 1'b1, 1'b0);
        fword(6'h19, 2'b00, 1'b1, 1'b1);
        fill_and_drain();
        @(posedge clk);
        pins_r.key_request_latch <= 1'b1;
        repeat (4) @(posedge clk);
        rx_char(7'h41, 1'b0);
        close_out();
    end
endmodule

`default_nettype wire
